// >>> hdl/alu8_pkg.sv
// package of constants and types for the 8-bit arithmetic and logic execution path
package alu8_pkg;

   // operation codes
   typedef enum logic [2:0]
   {
      ALU8_OP_ADD,
      ALU8_OP_ADC,
      ALU8_OP_SUB,
      ALU8_OP_SBC,
      ALU8_OP_AND,
      ALU8_OP_OR,
      ALU8_OP_XOR,
      ALU8_OP_COMP
   } alu8_op_t;

   // where the second operand comes from
   typedef enum logic [2:0]
   {
      ALU8_SRC_IMM,
      ALU8_SRC_REG,
      ALU8_SRC_SADDR,
      ALU8_SRC_ABS,
      ALU8_SRC_PTR,
      ALU8_SRC_PTR_DISP,
      ALU8_SRC_PTR_B,
      ALU8_SRC_PTR_C
   } alu8_src_t;

   // where the result goes
   typedef enum logic [1:0]
   {
      ALU8_DST_ACC,
      ALU8_DST_REG,
      ALU8_DST_MEM
   } alu8_dst_t;

   // data area kinds seen on the memory side
   typedef enum logic [1:0]
   {
      ALU8_AREA_RAM,
      ALU8_AREA_SFR,
      ALU8_AREA_XSFR,
      ALU8_AREA_FLASH
   } alu8_area_t;

   localparam int ALU8_DATA_W = 8;
   localparam int ALU8_ADDR_W = 20;
   localparam int ALU8_SEG_W = 4;
   localparam int ALU8_REGSEL_W = 3;
   localparam int ALU8_CNT_W = 4;
   localparam int ALU8_LEN_W = 3;

   // bit positions used for flags
   localparam int ALU8_AUX_BIT = 4;
   localparam int ALU8_CARRY_BIT = 8;

   // reset values
   localparam logic [7:0] ALU8_ACC_RST = 8'h00;
   localparam logic [3:0] ALU8_SEG_RST = 4'h0;
   localparam logic [15:0] ALU8_PTR_RST = 16'h0000;

   // short direct area base (upper byte of the 16-bit space)
   localparam logic [15:0] ALU8_SADDR_BASE = 16'hFE00;

   // cycle counts: short (ram/sfr/none) and flash read forms
   localparam logic [3:0] ALU8_CYC_BASE = 4'h1;
   localparam logic [3:0] ALU8_CYC_FLASH = 4'h4;
   localparam logic [3:0] ALU8_CYC_RMW = 4'h2;
   localparam logic [3:0] ALU8_CYC_SEG_EXTRA = 4'h1;

   // instruction lengths in bytes
   localparam logic [2:0] ALU8_LEN_IMM = 3'h2;
   localparam logic [2:0] ALU8_LEN_REG = 3'h2;
   localparam logic [2:0] ALU8_LEN_SADDR = 3'h2;
   localparam logic [2:0] ALU8_LEN_SADDR_IMM = 3'h3;
   localparam logic [2:0] ALU8_LEN_ABS = 3'h3;
   localparam logic [2:0] ALU8_LEN_ABS_IMM = 3'h4;
   localparam logic [2:0] ALU8_LEN_PTR = 3'h1;
   localparam logic [2:0] ALU8_LEN_PTR_IDX = 3'h2;
   localparam logic [2:0] ALU8_LEN_SEG_EXTRA = 3'h1;

   // fetch from ram: up to double plus this many clocks
   localparam logic [3:0] ALU8_RAM_FETCH_EXTRA = 4'h3;

endpackage

// >>> hdl/alu8_core.sv
// combinational 8-bit adder, subtractor and logic unit with flag outputs
`timescale 1ns/1ns
module alu8_core
(
   input wire alu8_pkg::alu8_op_t op,
   input wire logic [7:0] lhs,
   input wire logic [7:0] rhs,
   input wire logic carry_in,
   output logic [7:0] result,
   output logic zero,
   output logic aux,
   output logic carry,
   output logic arith
);
   import alu8_pkg::*;

   // nine-bit sums so the carry or borrow out of bit 7 is visible
   logic [8:0] full;
   // five-bit low-nibble sum for the bit-3 carry or borrow
   logic [4:0] low;
   logic cin;

   // carry in only for the carry-chained forms
   always_comb
   begin
      cin = ((op == ALU8_OP_ADC) || (op == ALU8_OP_SBC)) ? carry_in : 1'b0;
   end

   // main operation select
   always_comb
   begin
      full = 9'h000;
      low = 5'h00;
      arith = 1'b1;
      unique case (op)
         ALU8_OP_ADD, ALU8_OP_ADC:
         begin
            // sum and carry from the addition
            full = {1'b0, lhs} + {1'b0, rhs} + {8'h00, cin};
            low = {1'b0, lhs[3:0]} + {1'b0, rhs[3:0]} + {4'h0, cin};
         end
         ALU8_OP_SUB, ALU8_OP_SBC, ALU8_OP_COMP:
         begin
            // difference with borrow in bit 8
            full = {1'b0, lhs} - {1'b0, rhs} - {8'h00, cin};
            low = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]} - {4'h0, cin};
         end
         ALU8_OP_AND:
         begin
            full = {1'b0, lhs & rhs};
            arith = 1'b0;
         end
         ALU8_OP_OR:
         begin
            full = {1'b0, lhs | rhs};
            arith = 1'b0;
         end
         ALU8_OP_XOR:
         begin
            full = {1'b0, lhs ^ rhs};
            arith = 1'b0;
         end
      endcase
   end

   // flags: zero on 8-bit result, aux from bit 3, carry from bit 7
   always_comb
   begin
      result = full[7:0];
      zero = (full[7:0] == 8'h00);
      aux = low[ALU8_AUX_BIT];
      carry = full[ALU8_CARRY_BIT];
   end
endmodule

// >>> hdl/alu8_timing.sv
// cycle and length calculator for the 8-bit operation forms
`timescale 1ns/1ns
module alu8_timing
(
   input wire alu8_pkg::alu8_src_t src,
   input wire alu8_pkg::alu8_dst_t dst,
   input wire logic seg_prefix,
   input wire logic abs_imm,
   input wire alu8_pkg::alu8_area_t area,
   input wire logic fetch_from_ram,
   output logic [3:0] cycles,
   output logic [2:0] length
);
   import alu8_pkg::*;

   logic mem_read;
   logic [3:0] base;
   logic [4:0] doubled;

   // base cycles and byte length per form
   always_comb
   begin
      mem_read = 1'b1;
      base = ALU8_CYC_BASE;
      length = ALU8_LEN_IMM;
      unique case (src)
         ALU8_SRC_IMM:
         begin
            mem_read = 1'b0;
            length = ALU8_LEN_IMM;
         end
         ALU8_SRC_REG:
         begin
            mem_read = 1'b0;
            length = ALU8_LEN_REG;
         end
         ALU8_SRC_SADDR:
            length = (dst == ALU8_DST_MEM) ? ALU8_LEN_SADDR_IMM : ALU8_LEN_SADDR;
         ALU8_SRC_ABS:
            length = abs_imm ? ALU8_LEN_ABS_IMM : ALU8_LEN_ABS;
         ALU8_SRC_PTR:
            length = ALU8_LEN_PTR;
         ALU8_SRC_PTR_DISP, ALU8_SRC_PTR_B, ALU8_SRC_PTR_C:
            length = ALU8_LEN_PTR_IDX;
      endcase
      // read-modify-write of a short direct byte takes two clocks
      if (dst == ALU8_DST_MEM && !abs_imm)
      begin
         base = ALU8_CYC_RMW;
      end
      // longer count only when the data operand comes from flash
      else if (mem_read && area == ALU8_AREA_FLASH)
      begin
         base = ALU8_CYC_FLASH;
      end
      else
      begin
         base = ALU8_CYC_BASE;
      end
      // segment prefix adds one byte and one clock
      if (seg_prefix)
      begin
         base = base + ALU8_CYC_SEG_EXTRA;
         length = length + ALU8_LEN_SEG_EXTRA;
      end
   end

   // ram fetch worst case: double plus three
   always_comb
   begin
      doubled = {base, 1'b0} + {1'b0, ALU8_RAM_FETCH_EXTRA};
      cycles = fetch_from_ram ? doubled[3:0] : base;
   end
endmodule

// >>> hdl/alu8_exec.sv
// 8-bit arithmetic and logic execution path with operand fetch and flag update
`timescale 1ns/1ns
module alu8_exec
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire alu8_pkg::alu8_op_t op,
   input wire alu8_pkg::alu8_src_t src,
   input wire alu8_pkg::alu8_dst_t dst,
   input wire logic seg_prefix,
   input wire logic abs_imm,
   input wire logic fetch_from_ram,
   input wire logic [7:0] imm,
   input wire logic [7:0] disp,
   input wire logic [15:0] abs_addr,
   input wire logic [2:0] reg_sel,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] main_pointer_pair,
   input wire logic [7:0] index_b,
   input wire logic [7:0] index_c,
   input wire logic [3:0] segment_extension_register,
   input wire alu8_pkg::alu8_area_t area,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic done,
   output logic [3:0] cycles,
   output logic [2:0] length,
   output logic [19:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic reg_wr,
   output logic [2:0] reg_wsel,
   output logic [7:0] reg_wdata,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic aux_carry_flag,
   output logic carry_flag
);
   import alu8_pkg::*;

   // execution phases
   typedef enum logic [1:0]
   {
      ALU8_ST_IDLE,
      ALU8_ST_READ,
      ALU8_ST_WAIT,
      ALU8_ST_WRITE
   } alu8_state_t;

   alu8_state_t state;
   // latched operation
   alu8_op_t op_q;
   alu8_src_t src_q;
   alu8_dst_t dst_q;
   logic [2:0] reg_q;
   logic [7:0] imm_q;
   logic [7:0] reg_val_q;
   // operand held after memory read
   logic [7:0] operand_q;
   // remaining cycle count
   logic [3:0] remain;
   // combinational address, operands and results
   logic [15:0] next_absolute_address;
   logic [19:0] next_addr;
   logic [7:0] lhs;
   logic [7:0] rhs;
   logic [7:0] alu_result;
   logic alu_zero;
   logic alu_aux;
   logic alu_carry;
   logic alu_arith;
   logic [3:0] tim_cycles;
   logic [2:0] tim_length;
   logic mem_src;
   // operand seen this cycle: live read data while reading
   logic [7:0] rd_operand;

   // arithmetic unit
   alu8_core u_core
   (
      .op(op_q),
      .lhs(lhs),
      .rhs(rhs),
      .carry_in(carry_flag),
      .result(alu_result),
      .zero(alu_zero),
      .aux(alu_aux),
      .carry(alu_carry),
      .arith(alu_arith)
   );

   // cycle and length model
   alu8_timing u_timing
   (
      .src(src),
      .dst(dst),
      .seg_prefix(seg_prefix),
      .abs_imm(abs_imm),
      .area(area),
      .fetch_from_ram(fetch_from_ram),
      .cycles(tim_cycles),
      .length(tim_length)
   );

   // effective address from the requested form
   always_comb
   begin
      unique case (src)
         ALU8_SRC_SADDR:
            next_absolute_address = ALU8_SADDR_BASE | {8'h00, imm};
         ALU8_SRC_ABS:
            next_absolute_address = abs_addr;
         ALU8_SRC_PTR:
            next_absolute_address = main_pointer_pair;
         ALU8_SRC_PTR_DISP:
            next_absolute_address = main_pointer_pair + {8'h00, disp};
         ALU8_SRC_PTR_B:
            next_absolute_address = main_pointer_pair + {8'h00, index_b};
         ALU8_SRC_PTR_C:
            next_absolute_address = main_pointer_pair + {8'h00, index_c};
         default:
            next_absolute_address = 16'h0000;
      endcase
      // segment prefix places the extension register above the address
      next_addr = seg_prefix ? {segment_extension_register, next_absolute_address}
                             : {ALU8_SEG_RST, next_absolute_address};
      mem_src = (src != ALU8_SRC_IMM) && (src != ALU8_SRC_REG);
   end

   // operand routing: register-destination forms put the register first
   always_comb
   begin
      rd_operand = (state == ALU8_ST_READ) ? mem_rdata : operand_q;
      unique case (dst_q)
         ALU8_DST_REG:
         begin
            lhs = reg_val_q;
            rhs = acc;
         end
         ALU8_DST_MEM:
         begin
            lhs = rd_operand;
            rhs = imm_q;
         end
         default:
         begin
            lhs = acc;
            rhs = (src_q == ALU8_SRC_IMM) ? imm_q :
                  (src_q == ALU8_SRC_REG) ? reg_val_q : rd_operand;
         end
      endcase
   end

   // sequencing of request, read, wait and write
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= ALU8_ST_IDLE;
         remain <= 4'h0;
      end
      else
      begin
         unique case (state)
            ALU8_ST_IDLE:
            begin
               if (start)
               begin
                  remain <= tim_cycles - ALU8_CYC_BASE;
                  state <= mem_src ? ALU8_ST_READ : ALU8_ST_WAIT;
               end
            end
            ALU8_ST_READ:
            begin
               // operand arrives; finish or keep counting
               if (remain == 4'h0)
               begin
                  state <= (dst_q == ALU8_DST_MEM) ? ALU8_ST_WRITE : ALU8_ST_IDLE;
               end
               else
               begin
                  remain <= remain - 4'h1;
                  state <= ALU8_ST_WAIT;
               end
            end
            ALU8_ST_WAIT:
            begin
               // stretch to the required count
               if (remain <= 4'h1)
               begin
                  remain <= 4'h0;
                  state <= (dst_q == ALU8_DST_MEM) ? ALU8_ST_WRITE : ALU8_ST_IDLE;
               end
               else
               begin
                  remain <= remain - 4'h1;
               end
            end
            ALU8_ST_WRITE:
               state <= ALU8_ST_IDLE;
         endcase
      end
   end

   // latch the request when taken
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         op_q <= ALU8_OP_ADD;
         src_q <= ALU8_SRC_IMM;
         dst_q <= ALU8_DST_ACC;
         reg_q <= 3'h0;
         imm_q <= 8'h00;
         reg_val_q <= 8'h00;
         cycles <= 4'h0;
         length <= 3'h0;
         mem_addr <= 20'h0_0000;
      end
      else if (state == ALU8_ST_IDLE && start)
      begin
         op_q <= op;
         src_q <= src;
         // byte-versus-immediate compare runs as memory minus immediate
         dst_q <= abs_imm ? ALU8_DST_MEM : dst;
         reg_q <= reg_sel;
         imm_q <= imm;
         reg_val_q <= reg_rdata;
         cycles <= tim_cycles;
         length <= tim_length;
         mem_addr <= next_addr;
      end
   end

   // memory operand capture during the read phase
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         operand_q <= 8'h00;
      end
      else if (state == ALU8_ST_READ)
      begin
         operand_q <= mem_rdata;
      end
   end

   // memory strobes: read on entry, write back for read-modify-write
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_wdata <= 8'h00;
      end
      else
      begin
         mem_rd <= (state == ALU8_ST_IDLE) && start && mem_src;
         // compare never writes memory
         mem_wr <= (state == ALU8_ST_WRITE) && (op_q != ALU8_OP_COMP);
         // hold data in the write phase, when the carry is already new
         if (state != ALU8_ST_WRITE)
         begin
            mem_wdata <= alu_result;
         end
      end
   end

   // completion pulse and busy level
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         busy <= (state != ALU8_ST_IDLE) || start;
         done <= ((state == ALU8_ST_READ || state == ALU8_ST_WAIT)
                  && remain <= 4'h1 && dst_q != ALU8_DST_MEM && !(state == ALU8_ST_READ
                  && remain != 4'h0))
                 || (state == ALU8_ST_WRITE);
      end
   end

   // result writes to accumulator or register; compare writes nothing
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         acc <= ALU8_ACC_RST;
         reg_wr <= 1'b0;
         reg_wsel <= 3'h0;
         reg_wdata <= 8'h00;
      end
      else
      begin
         reg_wr <= 1'b0;
         if (state == ALU8_ST_WAIT || (state == ALU8_ST_READ && remain == 4'h0))
         begin
            if (remain <= 4'h1 && op_q != ALU8_OP_COMP)
            begin
               if (dst_q == ALU8_DST_ACC)
               begin
                  acc <= alu_result;
               end
               else if (dst_q == ALU8_DST_REG)
               begin
                  reg_wr <= 1'b1;
                  reg_wsel <= reg_q;
                  reg_wdata <= alu_result;
               end
            end
         end
      end
   end

   // flags: arithmetic updates all three, logic only zero
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         zero_flag <= 1'b0;
         aux_carry_flag <= 1'b0;
         carry_flag <= 1'b0;
      end
      else if ((state == ALU8_ST_WAIT && remain <= 4'h1)
               || (state == ALU8_ST_READ && remain == 4'h0))
      begin
         zero_flag <= alu_zero;
         if (alu_arith)
         begin
            aux_carry_flag <= alu_aux;
            carry_flag <= alu_carry;
         end
         // logic ops leave aux and carry alone
         else
         begin
            aux_carry_flag <= aux_carry_flag;
            carry_flag <= carry_flag;
         end
      end
   end
endmodule

// >>> verif/alu8_exec_assertions.sv
// assertion checker for the 8-bit execution path, bound to its ports
`timescale 1ns/1ns
module alu8_exec_checker
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire alu8_pkg::alu8_op_t op,
   input wire alu8_pkg::alu8_dst_t dst,
   input wire logic seg_prefix,
   input wire logic [3:0] segment_extension_register,
   input wire logic busy,
   input wire logic done,
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic reg_wr,
   input wire logic [7:0] acc,
   input wire logic zero_flag,
   input wire logic aux_carry_flag,
   input wire logic carry_flag
);
   import alu8_pkg::*;
   logic take; // request accepted at this edge
   logic is_logic; // running op touches only the zero flag
   alu8_op_t cur_op; // op of the running request
   alu8_dst_t cur_dst; // destination of the running request
   logic cur_seg; // prefix of the running request
   logic [3:0] cur_es; // extension value of the running request
   assign take = start && !busy && !done;
   assign is_logic = cur_op inside {ALU8_OP_AND, ALU8_OP_OR, ALU8_OP_XOR};
   // keep the fields of the taken request
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cur_op <= ALU8_OP_ADD;
         cur_dst <= ALU8_DST_ACC;
         cur_seg <= 1'b0;
         cur_es <= 4'h0;
      end
      else if (take)
      begin
         cur_op <= op;
         cur_dst <= dst;
         cur_seg <= seg_prefix;
         cur_es <= segment_extension_register;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   AST_TAKE_BUSY: assert property (take |=> busy)
      else $error("busy not raised after a taken start");
   AST_DONE_BOUND: assert property (take |-> ##[1:16] done)
      else $error("operation did not finish in time");
   AST_DONE_IDLE: assert property (done |=> !busy && !done)
      else $error("done not a single pulse ending busy");
   AST_COMP_KEEPS_ACC: assert property (busy && cur_op == ALU8_OP_COMP |-> $stable(acc))
      else $error("compare changed the accumulator");
   AST_LOGIC_KEEPS_CARRY: assert property (busy && is_logic |->
      $stable(carry_flag) && $stable(aux_carry_flag))
      else $error("logic op changed carry or aux carry");
   AST_ZERO_MATCH: assert property (done && cur_dst == ALU8_DST_ACC && cur_op != ALU8_OP_COMP
      |-> zero_flag == (acc == 8'h00))
      else $error("zero flag disagrees with accumulator");
   AST_REG_WR_DST: assert property (reg_wr |->
      cur_dst == ALU8_DST_REG && cur_op != ALU8_OP_COMP)
      else $error("register written by a form without register destination");
   AST_MEM_WR_DST: assert property (mem_wr |->
      cur_dst == ALU8_DST_MEM && cur_op != ALU8_OP_COMP)
      else $error("memory written by a form without memory destination");
   AST_SEG_ADDR: assert property (mem_rd && cur_seg |-> mem_addr[19:16] == cur_es)
      else $error("extension value missing from address");
   // main scenarios reached
   cover property (take && seg_prefix);
   cover property (mem_wr);
   cover property (reg_wr);
endmodule

bind alu8_exec alu8_exec_checker chk_u
(
   .core_clk(core_clk), .rst(rst), .start(start), .op(op), .dst(dst),
   .seg_prefix(seg_prefix), .segment_extension_register(segment_extension_register),
   .busy(busy), .done(done), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
   .reg_wr(reg_wr), .acc(acc), .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag),
   .carry_flag(carry_flag)
);

// >>> verif/alu8_mem_model.sv
// far-side memory model answering read strobes in the same cycle
`timescale 1ns/1ns
module alu8_mem_model
(
   input wire logic [19:0] mem_addr,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata
);
   // data stands while the read strobe is high, the inverse otherwise
   assign mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c ^ {8{!mem_rd}};
endmodule

// >>> verif/cpu_8bit_arith_logic_ops_test.sv
// self-checking bench for the 8-bit execution path
`timescale 1ns/1ns
module cpu_8bit_arith_logic_ops_test;
   import alu8_pkg::*;
   typedef struct packed
   {
      logic [19:0] acc;
      logic [19:0] flg;
      logic [19:0] cl;
      logic [19:0] w;
      logic [19:0] a;
      logic wr;
      logic mem;
   } alu8_exp_t;
   logic core_clk = 1'b0, rst = 1'b1, start = 1'b0, seg_prefix = 1'b0, abs_imm = 1'b0;
   logic fetch_from_ram = 1'b0;
   alu8_op_t op = ALU8_OP_ADD;
   alu8_src_t src = ALU8_SRC_IMM;
   alu8_dst_t dst = ALU8_DST_ACC;
   alu8_area_t area = ALU8_AREA_RAM;
   logic [7:0] imm = 8'h00, disp = 8'h00, reg_rdata = 8'h00, index_b = 8'h00, index_c = 8'h00;
   logic [15:0] abs_addr = 16'h0000, main_pointer_pair = 16'h0000;
   logic [2:0] reg_sel = 3'h0;
   logic [3:0] segment_extension_register = 4'h0;
   logic busy, done, mem_rd, mem_wr, reg_wr, zero_flag, aux_carry_flag, carry_flag;
   logic [3:0] cycles;
   logic [2:0] length, reg_wsel;
   logic [19:0] mem_addr, got_w, got_a;
   logic [7:0] mem_rdata, mem_wdata, reg_wdata, acc;
   logic [7:0] acc_m = 8'h00; // expected accumulator
   logic z_m = 1'b0, ac_m = 1'b0, cy_m = 1'b0; // expected flags
   alu8_exp_t expq[$]; // notes awaiting done
   alu8_exp_t me;
   integer seed = 86085, n_errors = 0, total_checks = 0, i, f, k;
   alu8_src_t fs[10] = '{ALU8_SRC_IMM, ALU8_SRC_REG, ALU8_SRC_REG, ALU8_SRC_SADDR,
      ALU8_SRC_SADDR, ALU8_SRC_ABS, ALU8_SRC_PTR, ALU8_SRC_PTR_DISP, ALU8_SRC_PTR_B,
      ALU8_SRC_PTR_C};
   alu8_dst_t fd[10] = '{ALU8_DST_ACC, ALU8_DST_ACC, ALU8_DST_REG, ALU8_DST_ACC, ALU8_DST_MEM,
      ALU8_DST_ACC, ALU8_DST_ACC, ALU8_DST_ACC, ALU8_DST_ACC, ALU8_DST_ACC};

   alu8_exec dut_u
   (
      .core_clk(core_clk), .rst(rst), .start(start), .op(op), .src(src), .dst(dst),
      .seg_prefix(seg_prefix), .abs_imm(abs_imm), .fetch_from_ram(fetch_from_ram), .imm(imm),
      .disp(disp), .abs_addr(abs_addr), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
      .main_pointer_pair(main_pointer_pair), .index_b(index_b), .index_c(index_c),
      .segment_extension_register(segment_extension_register), .area(area),
      .mem_rdata(mem_rdata), .busy(busy), .done(done), .cycles(cycles), .length(length),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .reg_wr(reg_wr), .reg_wsel(reg_wsel), .reg_wdata(reg_wdata), .acc(acc),
      .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag)
   );
   alu8_mem_model mem_u
   (
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata)
   );

   // free-running clock
   initial
   begin
      forever #5 core_clk = ~core_clk;
   end

   // one counted comparison
   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // one request: set inputs, note the expected outcome, pulse start, wait for done
   task automatic run(input alu8_op_t o, input int fi, input logic sg, input logic ai,
      input logic fr, input alu8_area_t ar, input logic [7:0] iv, input logic poke);
      alu8_exp_t e;
      alu8_src_t s;
      logic [15:0] a16;
      logic [7:0] md, lhs, rhs, res;
      logic [8:0] sum;
      logic sub, cin, ac;
      logic [3:0] base;
      int n;
      s = fs[fi];
      @(negedge core_clk);
      op = o;
      src = s;
      dst = fd[fi];
      seg_prefix = sg;
      abs_imm = ai;
      fetch_from_ram = fr;
      area = ar;
      imm = iv;
      disp = 8'($random(seed));
      abs_addr = 16'($random(seed));
      reg_sel = 3'($random(seed));
      reg_rdata = 8'($random(seed));
      main_pointer_pair = 16'($random(seed));
      index_b = 8'($random(seed));
      index_c = 8'($random(seed));
      segment_extension_register = 4'($random(seed));
      a16 = s == ALU8_SRC_SADDR ? {8'hfe, iv} : s == ALU8_SRC_ABS ? abs_addr :
         main_pointer_pair + (s == ALU8_SRC_PTR ? 16'h0000 : s == ALU8_SRC_PTR_DISP ?
         16'(disp) : s == ALU8_SRC_PTR_B ? 16'(index_b) : 16'(index_c));
      md = a16[7:0] ^ a16[15:8] ^ 8'h3c;
      lhs = fd[fi] == ALU8_DST_REG ? reg_rdata : (fd[fi] == ALU8_DST_MEM || ai) ? md : acc_m;
      rhs = fd[fi] == ALU8_DST_REG ? acc_m : (fd[fi] == ALU8_DST_MEM || ai) ? iv :
         s == ALU8_SRC_IMM ? iv : s == ALU8_SRC_REG ? reg_rdata : md;
      cin = (o == ALU8_OP_ADC || o == ALU8_OP_SBC) ? cy_m : 1'b0;
      sub = o inside {ALU8_OP_SUB, ALU8_OP_SBC, ALU8_OP_COMP};
      sum = sub ? 9'(lhs) - 9'(rhs) - 9'(cin) : 9'(lhs) + 9'(rhs) + 9'(cin);
      ac = sub ? 5'(lhs[3:0]) < 5'(rhs[3:0]) + 5'(cin) :
         5'(lhs[3:0]) + 5'(rhs[3:0]) + 5'(cin) > 5'h0f;
      res = o == ALU8_OP_AND ? lhs & rhs : o == ALU8_OP_OR ? lhs | rhs :
         o == ALU8_OP_XOR ? lhs ^ rhs : sum[7:0];
      z_m = res == 8'h00;
      if (!(o inside {ALU8_OP_AND, ALU8_OP_OR, ALU8_OP_XOR}))
      begin
         ac_m = ac;
         cy_m = sum[8];
      end
      if (fd[fi] == ALU8_DST_ACC && !ai && o != ALU8_OP_COMP)
         acc_m = res;
      base = fd[fi] == ALU8_DST_MEM ? 4'h2 : (s >= ALU8_SRC_ABS && ar == ALU8_AREA_FLASH) ?
         4'h4 : 4'h1;
      base = base + 4'(sg);
      e.cl = {9'h000, fr ? 4'(2 * base + 4'h3) : base, 4'h0, 3'(s == ALU8_SRC_PTR ? 1 :
         (s == ALU8_SRC_ABS || fd[fi] == ALU8_DST_MEM) ? 3 + 32'(ai) : 2) + 3'(sg)};
      e.acc = 20'(acc_m);
      e.flg = 20'({z_m, ac_m, cy_m});
      e.wr = fd[fi] != ALU8_DST_ACC;
      e.w = fd[fi] == ALU8_DST_REG ? 20'({reg_sel, res}) : 20'(res);
      e.mem = s >= ALU8_SRC_SADDR;
      e.a = {sg ? segment_extension_register : 4'h0, a16};
      expq.push_back(e);
      start = 1'b1;
      @(negedge core_clk);
      start = poke;
      @(negedge core_clk);
      start = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 40)
      begin
         @(negedge core_clk);
         n++;
      end
      check(20'(n == 40), 20'h0);
   endtask

   // take the oldest note whenever done appears and compare
   always @(negedge core_clk)
   begin
      if (reg_wr)
         got_w = 20'({reg_wsel, reg_wdata});
      if (mem_wr)
         got_w = 20'(mem_wdata);
      if (mem_rd || mem_wr)
         got_a = mem_addr;
      if (done === 1'b1)
      begin
         check(20'(expq.size() == 0), 20'h0);
         if (expq.size() != 0)
         begin
            me = expq.pop_front();
            check(20'(acc), me.acc);
            check(20'({zero_flag, aux_carry_flag, carry_flag}), me.flg);
            check(20'({cycles, 4'h0, length}), me.cl);
            if (me.wr)
               check(got_w, me.w);
            if (me.mem)
               check(got_a, me.a);
         end
         got_w = 'x;
         got_a = 'x;
      end
   end

   initial
   begin
      #200000;
      n_errors++;
      report_and_stop;
   end

   initial
   begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      // carry, borrow and zero boundaries through the accumulator
      run(ALU8_OP_ADD, 0, 0, 0, 0, ALU8_AREA_RAM, 8'hff, 0);
      run(ALU8_OP_ADD, 0, 0, 0, 0, ALU8_AREA_RAM, 8'h01, 0);
      run(ALU8_OP_ADC, 0, 0, 0, 0, ALU8_AREA_RAM, 8'h00, 0);
      run(ALU8_OP_SUB, 0, 0, 0, 0, ALU8_AREA_RAM, 8'h02, 0);
      run(ALU8_OP_SBC, 0, 0, 0, 0, ALU8_AREA_RAM, 8'h00, 0);
      run(ALU8_OP_COMP, 0, 0, 0, 0, ALU8_AREA_RAM, 8'hfe, 0);
      // every op in every form (compare only in the accumulator-destination forms), then again after a reset applied between the two passes
      for (k = 0; k < 2; k++)
      begin
         if (k == 1)
         begin
            @(negedge core_clk);
            rst = 1'b1;
            @(negedge core_clk);
            rst = 1'b0;
            acc_m = 8'h00;
            {z_m, ac_m, cy_m} = 3'h0;
            check(20'({acc, zero_flag, aux_carry_flag, carry_flag, busy}), 20'h0);
         end
         for (i = 0; i < 8; i++)
            for (f = 0; f < 10; f++)
               if (!(i == 7 && fd[f] != ALU8_DST_ACC))
                  run(alu8_op_t'(i), f, fs[f] >= ALU8_SRC_ABS && 1'($random(seed)),
                     i == 7 && f == 5 && k == 1, 2'($random(seed)) == 2'h0,
                     fs[f] >= ALU8_SRC_ABS ? alu8_area_t'(2'($random(seed))) :
                     fs[f] == ALU8_SRC_SADDR ? ALU8_AREA_SFR : ALU8_AREA_RAM,
                     8'($random(seed)), f == 7 && k == 0);
      end
      repeat (4) @(negedge core_clk);
      check(20'(expq.size()), 20'h0);
      report_and_stop;
   end
endmodule
